// ==== timer_regs.svh ====
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------------
// Register word index within a channel (bus_addr_in[2:0])
// ----------------------------------------------------------------------
`define REG_COUNTER 3'h0
`define REG_CMP_CAP_A 3'h1
`define REG_CMP_CAP_B 3'h2
`define REG_STAGE_A 3'h3
`define REG_STAGE_B 3'h4
`define REG_CTRL 3'h5
`define REG_STATUS 3'h6

// ----------------------------------------------------------------------
// Channel field (bus_addr_in[5:3]); value 5 is the shared block
// ----------------------------------------------------------------------
`define CHAN_COUNT 5
`define CHAN_SHARED 3'h5
`define REG_FUNC_CTRL 3'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define COUNTER_RESET 16'h0000
`define CMP_CAP_RESET 16'hFFFF
`define STAGE_RESET 16'hFFFF
`define COUNTER_CTRL_RESET 8'h80
`define PIN_FUNC_RESET 8'h88
`define FUNC_CTRL_RESET 8'hC0
`define COUNTER_MAX 16'hFFFF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCTL_CLR_HI 6
`define CCTL_CLR_LO 5
`define CCTL_EDGE_HI 4
`define CCTL_EDGE_LO 3
`define CCTL_EXT_BIT 2
`define CCTL_WR_MASK 8'h7F
`define PINF_B_CAP_BIT 6
`define PINF_B_EDGE_HI 5
`define PINF_B_EDGE_LO 4
`define PINF_A_CAP_BIT 2
`define PINF_A_EDGE_HI 1
`define PINF_A_EDGE_LO 0
`define PINF_WR_MASK 8'h77
`define STAT_FLAG_A 0
`define STAT_FLAG_B 1
`define STAT_WRAP 2
`define FUNC_WR_MASK 8'h3F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRESCALE_DIV_BITS 3

`endif

// ==== timer_pkg.sv ====
package timer_pkg;

   typedef logic [15:0] word_type;

   typedef enum logic [1:0] {
      CLR_NONE = 2'h0,
      CLR_ON_A = 2'h1,
      CLR_ON_B = 2'h2,
      CLR_SYNC = 2'h3
   } clear_mode_type;

   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_BOTH = 2'h2,
      EDGE_BOTH_ALT = 2'h3
   } edge_sel_type;

endpackage

// ==== edge_sense.sv ====
`timescale 1ns/1ps

module edge_sense (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic pin_in,
   output logic rise_out,
   output logic fall_out
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // ----------------------------------------------------------------------
   // Two-stage synchroniser, then edge history
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign rise_out = sync2_q & ~prev_q;
   assign fall_out = ~sync2_q & prev_q;

endmodule

// ==== five_channel_timer_counter_regs.sv ====
`timescale 1ns/1ps
`include "timer_regs.svh"

// Functional notes
// - Five 16-bit counters; channels 0,1 count up
// - Channel 2 up/down only in phase counting
// - Channels 3,4 up/down only in complementary PWM
// - Counter advances on prescale-selected source pulses
// - Clear on own A/B match or capture
// - Upward wrap FFFF to 0 sets wrap flag
// - Downward wrap 0 to FFFF sets wrap flag
// - Registers accessible by word or byte
// - Counters zero at reset and standby
// - Two general registers per channel, role by pin control
// - Compare role: equality on count sets flag
// - Capture role: latch counter on edge, flag
// - PWM modes ignore pin-function role settings
// - Reset/standby: general registers FFFF, compare role
// - Only channels 3,4 have two buffers each
// - Compare match copies buffer into general register
// - Capture moves old general value into buffer
// - Four separate buffer enable bits
// - Buffers FFFF at reset and standby
// - Clear select: none, A, B, synchronous
// - Internal divide 1/2/4/8 or external edges
module five_channel_timer_counter_regs (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic standby_in,
   input wire logic [5:0] bus_addr_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic [1:0] bus_byte_en_in,
   input wire logic [15:0] bus_wdata_in,
   output logic [15:0] bus_rdata_out,
   input wire logic [3:0] ext_clk_in,
   input wire logic [4:0] capture_a_in,
   input wire logic [4:0] capture_b_in,
   input wire logic [4:0] pwm_mode_in,
   input wire logic phase_count_mode_in,
   input wire logic comp_pwm_mode_in,
   input wire logic reset_sync_pwm_mode_in,
   input wire logic [4:0] count_down_in,
   input wire logic [4:0] sync_clear_in,
   output logic [4:0] match_a_out,
   output logic [4:0] match_b_out
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic timer_pkg::word_type merge16(input timer_pkg::word_type old_val,
                                                   input timer_pkg::word_type new_val,
                                                   input logic [1:0] lanes);
      timer_pkg::word_type res;
      res = old_val;
      if (lanes[1]) begin
         res[15:8] = new_val[15:8];
      end
      if (lanes[0]) begin
         res[7:0] = new_val[7:0];
      end
      return res;
   endfunction

   function automatic logic pick_edge(input logic rise, input logic fall, input logic [1:0] sel);
      logic res;
      res = 1'b0;
      case (timer_pkg::edge_sel_type'(sel))
         timer_pkg::EDGE_RISE: res = rise;
         timer_pkg::EDGE_FALL: res = fall;
         default: res = rise | fall;
      endcase
      return res;
   endfunction

   function automatic logic wr_hit(input logic [2:0] chan, input logic [2:0] reg_idx,
                                   input logic wr, input logic [5:0] addr);
      return wr && (addr[5:3] == chan) && (addr[2:0] == reg_idx);
   endfunction

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   timer_pkg::word_type counter_q [0:4];
   timer_pkg::word_type cmp_cap_a_q [0:4];
   timer_pkg::word_type cmp_cap_b_q [0:4];
   timer_pkg::word_type stage_a_q [3:4];
   timer_pkg::word_type stage_b_q [3:4];
   logic [7:0] counter_ctrl_q [0:4];
   logic [7:0] pin_func_q [0:4];
   logic [2:0] status_q [0:4];
   logic [7:0] func_ctrl_q;
   logic [`PRESCALE_DIV_BITS-1:0] div_q;
   logic [15:0] rdata_q;
   logic [4:0] match_a_q;
   logic [4:0] match_b_q;

   wire init_now = srst_in | standby_in;
   wire comp_or_resync = comp_pwm_mode_in | reset_sync_pwm_mode_in;

   // ----------------------------------------------------------------------
   // Internal prescaler: one-cycle enables at full rate, /2, /4, /8
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (init_now) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   wire [3:0] int_tick = {&div_q, &div_q[1:0], div_q[0], 1'b1};

   // ----------------------------------------------------------------------
   // Pin edge detection
   // ----------------------------------------------------------------------
   logic [3:0] ext_rise;
   logic [3:0] ext_fall;
   logic [4:0] cap_a_rise;
   logic [4:0] cap_a_fall;
   logic [4:0] cap_b_rise;
   logic [4:0] cap_b_fall;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ext
         edge_sense u_ext (
            .core_clk_in(core_clk_in),
            .srst_in(srst_in),
            .pin_in(ext_clk_in[gi]),
            .rise_out(ext_rise[gi]),
            .fall_out(ext_fall[gi])
         );
      end
      for (gi = 0; gi < `CHAN_COUNT; gi++) begin : g_cap
         edge_sense u_cap_a (
            .core_clk_in(core_clk_in),
            .srst_in(srst_in),
            .pin_in(capture_a_in[gi]),
            .rise_out(cap_a_rise[gi]),
            .fall_out(cap_a_fall[gi])
         );
         edge_sense u_cap_b (
            .core_clk_in(core_clk_in),
            .srst_in(srst_in),
            .pin_in(capture_b_in[gi]),
            .rise_out(cap_b_rise[gi]),
            .fall_out(cap_b_fall[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Shared function control: buffer enables a3, b3, a4, b4 in bits 0..3
   // ----------------------------------------------------------------------
   wire func_wr = wr_hit(`CHAN_SHARED, `REG_FUNC_CTRL, bus_wr_in, bus_addr_in) & bus_byte_en_in[0];

   always_ff @(posedge core_clk_in) begin
      if (init_now) begin
         func_ctrl_q <= `FUNC_CTRL_RESET;
      end else if (func_wr) begin
         func_ctrl_q <= (bus_wdata_in[7:0] & `FUNC_WR_MASK) | (`FUNC_CTRL_RESET & ~`FUNC_WR_MASK);
      end
   end

   // ----------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
         localparam logic [2:0] CH = 3'(ch);
         wire [7:0] cctl = counter_ctrl_q[ch];
         wire [7:0] pinf = pin_func_q[ch];
         wire [2:0] psc = cctl[2:0];
         wire [1:0] clr_sel = cctl[`CCTL_CLR_HI:`CCTL_CLR_LO];
         wire [1:0] ext_sel = cctl[`CCTL_EDGE_HI:`CCTL_EDGE_LO];
         wire phase_here = (ch == 2) && phase_count_mode_in;
         // Phase counting itself lives elsewhere; here it is any edge on clocks A and B
         wire phase_tick = ext_rise[0] | ext_fall[0] | ext_rise[1] | ext_fall[1];
         wire sel_tick = psc[`CCTL_EXT_BIT] ?
                         pick_edge(ext_rise[psc[1:0]], ext_fall[psc[1:0]], ext_sel) :
                         int_tick[psc[1:0]];
         wire tick = phase_here ? phase_tick : sel_tick;
         wire down = (ch == 2) ? (phase_count_mode_in & count_down_in[ch]) :
                     (ch >= 3) ? (comp_pwm_mode_in & count_down_in[ch]) :
                     1'b0;
         // PWM modes force compare role so stale capture settings cannot misfire
         wire pwm_any = pwm_mode_in[ch] | ((ch >= 3) & comp_or_resync);
         wire cap_role_a = ~pwm_any & pinf[`PINF_A_CAP_BIT];
         wire cap_role_b = ~pwm_any & pinf[`PINF_B_CAP_BIT];
         wire cap_a = cap_role_a & pick_edge(cap_a_rise[ch], cap_a_fall[ch],
                                             pinf[`PINF_A_EDGE_HI:`PINF_A_EDGE_LO]);
         wire cap_b = cap_role_b & pick_edge(cap_b_rise[ch], cap_b_fall[ch],
                                             pinf[`PINF_B_EDGE_HI:`PINF_B_EDGE_LO]);
         wire match_a = ~cap_role_a & tick & (counter_q[ch] == cmp_cap_a_q[ch]);
         wire match_b = ~cap_role_b & tick & (counter_q[ch] == cmp_cap_b_q[ch]);
         wire clear = ((timer_pkg::clear_mode_type'(clr_sel) == timer_pkg::CLR_ON_A) & (match_a | cap_a)) |
                      ((timer_pkg::clear_mode_type'(clr_sel) == timer_pkg::CLR_ON_B) & (match_b | cap_b)) |
                      ((timer_pkg::clear_mode_type'(clr_sel) == timer_pkg::CLR_SYNC) & sync_clear_in[ch]);
         wire wrap = tick & ~clear & (down ? (counter_q[ch] == `COUNTER_RESET) :
                                             (counter_q[ch] == `COUNTER_MAX));
         wire wr_cnt = wr_hit(CH, `REG_COUNTER, bus_wr_in, bus_addr_in);
         wire wr_a = wr_hit(CH, `REG_CMP_CAP_A, bus_wr_in, bus_addr_in);
         wire wr_b = wr_hit(CH, `REG_CMP_CAP_B, bus_wr_in, bus_addr_in);
         wire wr_ctl = wr_hit(CH, `REG_CTRL, bus_wr_in, bus_addr_in);
         wire wr_st = wr_hit(CH, `REG_STATUS, bus_wr_in, bus_addr_in) & bus_byte_en_in[0];
         logic buf_a;
         logic buf_b;
         timer_pkg::word_type counter_d;
         timer_pkg::word_type cmp_a_d;
         timer_pkg::word_type cmp_b_d;
         logic [2:0] status_d;

         if (ch >= 3) begin : g_buf
            assign buf_a = func_ctrl_q[2*(ch-3)];
            assign buf_b = func_ctrl_q[2*(ch-3)+1];
            always_ff @(posedge core_clk_in) begin
               if (init_now) begin
                  stage_a_q[ch] <= `STAGE_RESET;
                  stage_b_q[ch] <= `STAGE_RESET;
               end else begin
                  if (wr_hit(CH, `REG_STAGE_A, bus_wr_in, bus_addr_in)) begin
                     stage_a_q[ch] <= merge16(stage_a_q[ch], bus_wdata_in, bus_byte_en_in);
                  end else if (buf_a & cap_a) begin
                     stage_a_q[ch] <= cmp_cap_a_q[ch];
                  end
                  if (wr_hit(CH, `REG_STAGE_B, bus_wr_in, bus_addr_in)) begin
                     stage_b_q[ch] <= merge16(stage_b_q[ch], bus_wdata_in, bus_byte_en_in);
                  end else if (buf_b & cap_b) begin
                     stage_b_q[ch] <= cmp_cap_b_q[ch];
                  end
               end
            end
         end else begin : g_nobuf
            // Channels 0..2 have no staging registers
            assign buf_a = 1'b0;
            assign buf_b = 1'b0;
         end

         always_comb begin
            counter_d = counter_q[ch];
            if (wr_cnt) begin
               counter_d = merge16(counter_q[ch], bus_wdata_in, bus_byte_en_in);
            end else if (clear) begin
               counter_d = `COUNTER_RESET;
            end else if (tick) begin
               counter_d = down ? counter_q[ch] - 16'h0001 : counter_q[ch] + 16'h0001;
            end
         end

         always_comb begin
            cmp_a_d = cmp_cap_a_q[ch];
            if (wr_a) begin
               cmp_a_d = merge16(cmp_cap_a_q[ch], bus_wdata_in, bus_byte_en_in);
            end else if (cap_a) begin
               cmp_a_d = counter_q[ch];
            end else if (match_a & buf_a) begin
               cmp_a_d = stage_value(1'b0);
            end
            cmp_b_d = cmp_cap_b_q[ch];
            if (wr_b) begin
               cmp_b_d = merge16(cmp_cap_b_q[ch], bus_wdata_in, bus_byte_en_in);
            end else if (cap_b) begin
               cmp_b_d = counter_q[ch];
            end else if (match_b & buf_b) begin
               cmp_b_d = stage_value(1'b1);
            end
         end

         function automatic timer_pkg::word_type stage_value(input logic sel_b);
            timer_pkg::word_type res;
            res = `STAGE_RESET;
            if (ch >= 3) begin
               res = sel_b ? stage_b_q[(ch >= 3) ? ch : 3] : stage_a_q[(ch >= 3) ? ch : 3];
            end
            return res;
         endfunction

         // Hardware set wins over a software clear in the same cycle
         always_comb begin
            status_d = status_q[ch];
            if (wr_st) begin
               status_d = status_q[ch] & ~bus_wdata_in[2:0];
            end
            status_d[`STAT_FLAG_A] = status_d[`STAT_FLAG_A] | match_a | cap_a;
            status_d[`STAT_FLAG_B] = status_d[`STAT_FLAG_B] | match_b | cap_b;
            status_d[`STAT_WRAP] = status_d[`STAT_WRAP] | wrap;
         end

         always_ff @(posedge core_clk_in) begin
            if (init_now) begin
               counter_q[ch] <= `COUNTER_RESET;
               cmp_cap_a_q[ch] <= `CMP_CAP_RESET;
               cmp_cap_b_q[ch] <= `CMP_CAP_RESET;
               counter_ctrl_q[ch] <= `COUNTER_CTRL_RESET;
               pin_func_q[ch] <= `PIN_FUNC_RESET;
               status_q[ch] <= 3'h0;
               match_a_q[ch] <= 1'b0;
               match_b_q[ch] <= 1'b0;
            end else begin
               counter_q[ch] <= counter_d;
               cmp_cap_a_q[ch] <= cmp_a_d;
               cmp_cap_b_q[ch] <= cmp_b_d;
               status_q[ch] <= status_d;
               match_a_q[ch] <= match_a;
               match_b_q[ch] <= match_b;
               if (wr_ctl & bus_byte_en_in[0]) begin
                  counter_ctrl_q[ch] <= (bus_wdata_in[7:0] & `CCTL_WR_MASK) | (`COUNTER_CTRL_RESET & ~`CCTL_WR_MASK);
               end
               if (wr_ctl & bus_byte_en_in[1]) begin
                  pin_func_q[ch] <= (bus_wdata_in[15:8] & `PINF_WR_MASK) | (`PIN_FUNC_RESET & ~`PINF_WR_MASK);
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read path: one cycle after bus_rd_in, unmapped reads return zero
   // ----------------------------------------------------------------------
   wire [2:0] rd_ch = bus_addr_in[5:3];
   wire [2:0] rd_reg = bus_addr_in[2:0];
   wire rd_chan_ok = rd_ch < 3'h5;
   wire [2:0] rd_idx = rd_chan_ok ? rd_ch : 3'h0;
   wire rd_has_buf = (rd_ch == 3'h3) || (rd_ch == 3'h4);
   wire [2:0] rd_buf_idx = rd_has_buf ? rd_ch : 3'h3;
   logic [15:0] rd_word;

   always_comb begin
      rd_word = 16'h0000;
      if (rd_chan_ok) begin
         case (rd_reg)
            `REG_COUNTER: rd_word = counter_q[rd_idx];
            `REG_CMP_CAP_A: rd_word = cmp_cap_a_q[rd_idx];
            `REG_CMP_CAP_B: rd_word = cmp_cap_b_q[rd_idx];
            `REG_STAGE_A: rd_word = rd_has_buf ? stage_a_q[rd_buf_idx] : 16'h0000;
            `REG_STAGE_B: rd_word = rd_has_buf ? stage_b_q[rd_buf_idx] : 16'h0000;
            `REG_CTRL: rd_word = {pin_func_q[rd_idx], counter_ctrl_q[rd_idx]};
            `REG_STATUS: rd_word = {13'h0000, status_q[rd_idx]};
            default: rd_word = 16'h0000;
         endcase
      end else if ((rd_ch == `CHAN_SHARED) && (rd_reg == `REG_FUNC_CTRL)) begin
         rd_word = {8'h00, func_ctrl_q};
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rdata_q <= 16'h0000;
      end else if (bus_rd_in) begin
         rdata_q <= rd_word;
      end
   end

   assign bus_rdata_out = rdata_q;
   assign match_a_out = match_a_q;
   assign match_b_out = match_b_q;

endmodule

// ==== timer_regs_properties.sv ====
`timescale 1ns/1ps
`include "timer_regs.svh"
// ----------------------------------------
// Bus and standby checks
// ----------------------------------------
module timer_regs_checker (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic standby_in,
   input wire logic [5:0] bus_addr_in,
   input wire logic bus_rd_in,
   input wire logic [15:0] bus_rdata_out,
   input wire logic [4:0] match_a_out,
   input wire logic [4:0] match_b_out
);
   wire logic [2:0] chan = bus_addr_in[5:3];
   wire logic [2:0] idx = bus_addr_in[2:0];
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);
   // A read on the first standby edge may still see older state
   sequence s_sb_rd(logic [2:0] ri);
      standby_in ##1 (standby_in && bus_rd_in && idx == ri && chan < `CHAN_SHARED);
   endsequence
   property p_sb_cnt; s_sb_rd(`REG_COUNTER) |=> bus_rdata_out == `COUNTER_RESET; endproperty
   a_sb_cnt: assert property (p_sb_cnt) else $error("counter not zero in standby");
   property p_sb_gen; (s_sb_rd(`REG_CMP_CAP_A) or s_sb_rd(`REG_CMP_CAP_B)) |=> bus_rdata_out == `CMP_CAP_RESET;
   endproperty
   a_sb_gen: assert property (p_sb_gen) else $error("general reg not FFFF in standby");
   property p_sb_stg; (s_sb_rd(`REG_STAGE_A) or s_sb_rd(`REG_STAGE_B)) ##0 chan > 3'h2
      |=> bus_rdata_out == `STAGE_RESET; endproperty
   a_sb_stg: assert property (p_sb_stg) else $error("buffer not FFFF in standby");
   property p_sb_ctl; s_sb_rd(`REG_CTRL) |=> bus_rdata_out == {`PIN_FUNC_RESET, `COUNTER_CTRL_RESET}; endproperty
   a_sb_ctl: assert property (p_sb_ctl) else $error("control not at reset in standby");
   property p_no_stg; bus_rd_in && chan < 3'h3 && (idx == `REG_STAGE_A || idx == `REG_STAGE_B)
      |=> bus_rdata_out == 16'h0000; endproperty
   a_no_stg: assert property (p_no_stg) else $error("buffer present on channel 0 to 2");
   property p_unmap; bus_rd_in && (idx == 3'h7 || chan > `CHAN_SHARED || (chan == `CHAN_SHARED && idx != 3'h0))
      |=> bus_rdata_out == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_hold; !bus_rd_in |=> $stable(bus_rdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
   property p_quiet; standby_in ##1 standby_in |-> match_a_out == 5'h00 && match_b_out == 5'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("match pulse in standby");
endmodule
bind five_channel_timer_counter_regs timer_regs_checker i_timer_regs_checker (
   .core_clk_in(core_clk_in), .srst_in(srst_in), .standby_in(standby_in), .bus_addr_in(bus_addr_in),
   .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .match_a_out(match_a_out), .match_b_out(match_b_out)
);

// ==== timer_cpu_model.sv ====
`timescale 1ns/1ps
module timer_cpu_model (
   input wire logic core_clk_in,
   output logic [5:0] bus_addr_out,
   output logic bus_wr_out,
   output logic bus_rd_out,
   output logic [1:0] bus_byte_en_out,
   output logic [15:0] bus_wdata_out
);
   initial {bus_addr_out, bus_wr_out, bus_rd_out, bus_byte_en_out, bus_wdata_out} = '0;
   // Idle address, byte-enable and data lines show the inverse of the last access so stale values never look valid
   task automatic access(input logic wr, input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge core_clk_in);
      bus_addr_out <= a;
      bus_byte_en_out <= be;
      bus_wdata_out <= d;
      bus_wr_out <= wr;
      bus_rd_out <= !wr;
      @(posedge core_clk_in);
      bus_wr_out <= 1'b0;
      bus_rd_out <= 1'b0;
      bus_addr_out <= ~a;
      bus_byte_en_out <= ~be;
      bus_wdata_out <= ~d;
   endtask
endmodule

// ==== five_channel_timer_counter_regs_tb.sv ====
`timescale 1ns/1ps
`include "timer_regs.svh"
module five_channel_timer_counter_regs_tb;
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic standby_in = 1'b1;
   logic ext_a = 1'b0, phase = 1'b0, comp = 1'b0, rd_seen = 1'b0, bus_wr, bus_rd;
   logic [1:0] ext_hi = 2'h0, bus_be;
   logic [4:0] cap_a = 5'h00, sync_clr = 5'h00, cnt_dn = 5'h1F, mat_a, mat_b;
   logic [9:0] hit_q[$];
   logic [5:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata;
   logic [31:0] rnd_q = 32'h80CA7495;
   logic [15:0] exp_q[$];
   int err_total = 0, tests_run = 0;
   always #2 core_clk_in = ~core_clk_in;
   five_channel_timer_counter_regs i_five_channel_timer_counter_regs (
      .core_clk_in(core_clk_in), .srst_in(srst_in), .standby_in(standby_in), .bus_addr_in(bus_addr),
      .bus_wr_in(bus_wr), .bus_rd_in(bus_rd), .bus_byte_en_in(bus_be), .bus_wdata_in(bus_wdata),
      .bus_rdata_out(bus_rdata), .ext_clk_in({ext_hi, 1'b0, ext_a}), .capture_a_in(cap_a),
      .capture_b_in(5'h00), .pwm_mode_in(5'h00), .phase_count_mode_in(phase), .comp_pwm_mode_in(comp),
      .reset_sync_pwm_mode_in(1'b0), .count_down_in(cnt_dn), .sync_clear_in(sync_clr),
      .match_a_out(mat_a), .match_b_out(mat_b)
   );
   timer_cpu_model i_timer_cpu_model (
      .core_clk_in(core_clk_in), .bus_addr_out(bus_addr), .bus_wr_out(bus_wr), .bus_rd_out(bus_rd),
      .bus_byte_en_out(bus_be), .bus_wdata_out(bus_wdata)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
      i_timer_cpu_model.access(1'b1, a, be, d);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      i_timer_cpu_model.access(1'b0, a, 2'h3, 16'h0000);
   endtask
   // Sync plus edge detect needs about three cycles, so each level is held for six
   task automatic pulses(input int n);
      repeat (n) begin
         ext_a <= 1'b1;
         repeat (6) @(posedge core_clk_in);
         ext_a <= 1'b0;
         repeat (6) @(posedge core_clk_in);
      end
   endtask
   task automatic count_case(input logic [2:0] c, input logic [15:0] s, input int n, input logic [15:0] ec,
                             input logic [15:0] es);
      wr({c, `REG_COUNTER}, 2'h3, s);
      wr({c, `REG_STATUS}, 2'h1, 16'h0007);
      pulses(n);
      rd_chk({c, `REG_COUNTER}, ec);
      rd_chk({c, `REG_STATUS}, es);
   endtask
   always @(posedge core_clk_in) begin
      rd_seen <= bus_rd;
      rnd_q <= lfsr(rnd_q);
      ext_hi <= rnd_q[1:0];
      if (rd_seen && exp_q.size() > 0) begin
         check(bus_rdata, exp_q.pop_front());
      end
      if ({mat_a, mat_b} != 10'h000 && hit_q.size() > 0) begin
         check({6'h00, mat_a, mat_b}, {6'h00, hit_q.pop_front()});
      end
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      err_total++;
      stop_test();
   end
   initial begin
      logic [15:0] e, d;
      repeat (20) @(posedge core_clk_in);
      srst_in <= 1'b0;
      // Standby holds the counters in reset, so reset values read back exactly
      for (int c = 0; c < 5; c++) begin
         for (int i = 0; i < 8; i++) begin
            e = (i == 1 || i == 2 || (c > 2 && (i == 3 || i == 4))) ? 16'hFFFF : 16'h0000;
            rd_chk({c[2:0], i[2:0]}, (i == 5) ? 16'h8880 : e);
         end
      end
      rd_chk({`CHAN_SHARED, `REG_FUNC_CTRL}, 16'h00C0);
      rd_chk(6'h31, 16'h0000);
      $display("test reset_values done");
      standby_in <= 1'b0;
      for (int c = 0; c < 5; c++) begin
         wr({c[2:0], `REG_CTRL}, 2'h1, 16'h0004);
         for (int i = 1; i < 5; i++) begin
            e = rnd_q[15:0];
            wr({c[2:0], i[2:0]}, 2'h3, e);
            d = {~e[15:8], rnd_q[7:0]};
            wr({c[2:0], i[2:0]}, 2'h1, d);
            e = (c < 3 && i > 2) ? 16'h0000 : {e[15:8], d[7:0]};
            rd_chk({c[2:0], i[2:0]}, e);
            wr({c[2:0], i[2:0]}, 2'h3, 16'h7000);
         end
      end
      $display("test access done");
      for (int c = 0; c < 5; c++) begin
         count_case(c[2:0], 16'hFFFE, 3, 16'h0001, 16'h0004);
      end
      comp <= 1'b1;
      count_case(3'h3, 16'h0001, 2, 16'hFFFF, 16'h0004);
      cnt_dn <= 5'h00;
      count_case(3'h4, 16'hFFFE, 3, 16'h0001, 16'h0004);
      cnt_dn <= 5'h1F;
      count_case(3'h0, 16'hFFFE, 3, 16'h0001, 16'h0004);
      comp <= 1'b0;
      phase <= 1'b1;
      count_case(3'h2, 16'h0001, 1, 16'hFFFF, 16'h0004);
      phase <= 1'b0;
      $display("test count done");
      wr(6'h0D, 2'h1, 16'h0024);
      wr(6'h09, 2'h3, 16'h0005);
      hit_q.push_back(10'h040);
      count_case(3'h1, 16'h0003, 3, 16'h0000, 16'h0001);
      wr(6'h0D, 2'h1, 16'h0044);
      wr(6'h0A, 2'h3, 16'h0005);
      hit_q.push_back(10'h042);
      count_case(3'h1, 16'h0003, 3, 16'h0000, 16'h0003);
      wr(6'h0D, 2'h1, 16'h0064);
      wr(6'h08, 2'h3, 16'h1234);
      sync_clr <= 5'h02;
      @(posedge core_clk_in);
      sync_clr <= 5'h00;
      rd_chk(6'h08, 16'h0000);
      $display("test clear done");
      wr(6'h28, 2'h1, 16'h0001);
      wr(6'h1B, 2'h3, 16'hAAAA);
      wr(6'h19, 2'h3, 16'h1111);
      wr(6'h1D, 2'h2, 16'h0400);
      wr(6'h18, 2'h3, 16'h0123);
      wr(6'h1E, 2'h1, 16'h0007);
      cap_a <= 5'h08;
      repeat (6) @(posedge core_clk_in);
      cap_a <= 5'h00;
      rd_chk(6'h19, 16'h0123);
      rd_chk(6'h1B, 16'h1111);
      rd_chk(6'h1E, 16'h0001);
      wr(6'h28, 2'h1, 16'h0008);
      wr(6'h24, 2'h3, 16'h5A5A);
      wr(6'h22, 2'h3, 16'h0006);
      wr(6'h20, 2'h3, 16'h0005);
      hit_q.push_back(10'h010);
      pulses(2);
      rd_chk(6'h22, 16'h5A5A);
      rd_chk(6'h20, 16'h0007);
      $display("test capture_buffer done");
      standby_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      rd_chk(6'h20, 16'h0000);
      rd_chk(6'h22, 16'hFFFF);
      rd_chk(6'h24, 16'hFFFF);
      standby_in <= 1'b0;
      wr(6'h0D, 2'h1, 16'h0003);
      repeat (9) @(posedge core_clk_in);
      rd_chk(6'h08, 16'h0003);
      rd_chk(6'h00, 16'h000E);
      repeat (4) @(posedge core_clk_in);
      check(16'(hit_q.size()), 16'h0000);
      $display("test standby_prescale done");
      stop_test();
   end
endmodule
